/* boot_mode_pin_function_select.sv */
`timescale 1ns/1ns

// Notes on behaviour
// - Mode pins choose mode and pin functions
// - Software override registers alter pin functions
// - Mode change selects matching memory remap
// - Mode 2 gives 8-bit, 16MB bus
// - Mode 3 gives 16-bit bus, upper data
// - Mode 4 flash boot with 16-bit bus
// - Mode 5 flash single-chip, bus pins GPIO, upper address and upper chip selects to timers
// - Mode 6 UART boot with 16-bit bus
// - Mode 7 UART boot single-chip, no bus
// - Timer A/B pins: PWM, compare, capture
// - Timer clocks share port A bits 0-3
// - Interrupt inputs share port 8 and 7
// - Chip selects share port 8 bits 1-4
// - Address 20-23 share port A 4-7
module boot_mode_pin_function_select #(
  parameter int GROUPS = pin_function_select_pkg::GRP_COUNT
) (
  input  wire logic                            clock,
  input  wire logic                            reset,
  input  wire logic [pin_function_select_pkg::MODE_W-1:0]  mode_pin,
  input  wire logic                            resample,
  input  wire logic                            ovr_we,
  input  wire logic [3:0]                      ovr_grp,
  input  wire pin_function_select_pkg::grp_ovr_s           ovr_wdata,
  output pin_function_select_pkg::op_mode_e                op_mode,
  output logic                                 mode_valid,
  output logic                                 test_mode,
  output pin_function_select_pkg::remap_e                  mem_remap,
  output logic                                 ext_bus_en,
  output logic                                 ext_bus_wide,
  output logic                                 single_chip_mode,
  output logic                                 boot_uart,
  output pin_function_select_pkg::pin_sel_s                pin_function_select
);

  localparam int                  SETTLE_W    = 2;
  localparam int                  GRP_IDX_W   = 4;
  localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(pin_function_select_pkg::SYNC_STAGES);

  typedef logic [pin_function_select_pkg::MODE_W-1:0] mode_code_t;

  // Strap pins come from the board, so two flops before any use
  mode_code_t            mode_meta_r;
  mode_code_t            mode_sync_r;

  // Capture waits until the synchroniser holds the new code
  logic [SETTLE_W-1:0]   settle_r;
  logic                  pending_r;
  logic                  capture;

  // Decode of the synchronised code
  pin_function_select_pkg::op_mode_e mode_dec;
  pin_function_select_pkg::remap_e   dec_remap;
  logic                  dec_test;
  logic                  dec_bus;
  logic                  dec_wide;
  logic                  dec_chip;
  logic                  dec_uart;

  // Software override table, one word per pin group
  pin_function_select_pkg::grp_ovr_s ovr_r [GROUPS];

  // Per-group function from the mode and after the override
  pin_function_select_pkg::pin_fn_e  mode_fn  [GROUPS];
  pin_function_select_pkg::pin_fn_e  final_fn [GROUPS];

  logic [GROUPS-1:0]     bus_nxt;
  logic [GROUPS-1:0]     gpio_nxt;
  logic [GROUPS-1:0]     timer_nxt;
  logic [GROUPS-1:0]     alt_nxt;

  function automatic pin_function_select_pkg::pin_fn_e group_default(
    input int   grp,
    input logic test,
    input logic bus,
    input logic wide,
    input logic chip,
    input logic uart
  );
    pin_function_select_pkg::pin_fn_e fn;
    fn = pin_function_select_pkg::FN_GPIO;
    if (test) begin
      // Test codes hand every pin to the test function
      fn = pin_function_select_pkg::FN_ALT;
    end else if (grp == pin_function_select_pkg::GRP_DATA_LO) begin
      fn = bus ? pin_function_select_pkg::FN_BUS : pin_function_select_pkg::FN_GPIO;
    end else if (grp == pin_function_select_pkg::GRP_DATA_HI) begin
      fn = wide ? pin_function_select_pkg::FN_BUS : pin_function_select_pkg::FN_GPIO;
    end else if (grp == pin_function_select_pkg::GRP_ADDR_LO) begin
      fn = bus ? pin_function_select_pkg::FN_BUS : pin_function_select_pkg::FN_GPIO;
    end else if (grp == pin_function_select_pkg::GRP_ADDR_HI) begin
      // UART boot and single-chip modes give these pins to timers 1 and 2
      fn = (bus && !uart) ? pin_function_select_pkg::FN_BUS : pin_function_select_pkg::FN_TIMER;
    end else if (grp == pin_function_select_pkg::GRP_STROBE) begin
      fn = bus ? pin_function_select_pkg::FN_BUS : pin_function_select_pkg::FN_GPIO;
    end else if (grp == pin_function_select_pkg::GRP_CS_HI) begin
      fn = chip ? pin_function_select_pkg::FN_TIMER : pin_function_select_pkg::FN_BUS;
    end else if (grp == pin_function_select_pkg::GRP_CS_LO) begin
      // Interrupt inputs on these pins are reached by override only
      fn = bus ? pin_function_select_pkg::FN_BUS : pin_function_select_pkg::FN_GPIO;
    end else if (grp == pin_function_select_pkg::GRP_TIMER5) begin
      fn = pin_function_select_pkg::FN_TIMER;
    end else if (grp == pin_function_select_pkg::GRP_TCLK) begin
      fn = pin_function_select_pkg::FN_TIMER;
    end
    return fn;
  endfunction

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_meta_r <= '0;
      mode_sync_r <= '0;
    end else begin
      mode_meta_r <= mode_pin;
      mode_sync_r <= mode_meta_r;
    end
  end

  // A resample restarts the wait, so a code changed with it is not missed
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      settle_r  <= SETTLE_LOAD;
      pending_r <= 1'b1;
    end else if (resample) begin
      settle_r  <= SETTLE_LOAD;
      pending_r <= 1'b1;
    end else if (pending_r) begin
      if (settle_r == '0) begin
        pending_r <= 1'b0;
      end else begin
        settle_r <= settle_r - 2'h1;
      end
    end
  end

  assign capture = pending_r && (settle_r == '0) && !resample;

  always_comb begin
    mode_dec  = pin_function_select_pkg::op_mode_e'(mode_sync_r);
    dec_remap = pin_function_select_pkg::REMAP_TEST;
    dec_test  = 1'b0;
    dec_bus   = 1'b0;
    dec_wide  = 1'b0;
    dec_chip  = 1'b0;
    dec_uart  = 1'b0;
    case (mode_dec)
      pin_function_select_pkg::MODE_TEST0, pin_function_select_pkg::MODE_TEST1: begin
        dec_test  = 1'b1;
        dec_remap = pin_function_select_pkg::REMAP_TEST;
      end
      pin_function_select_pkg::MODE_EXT_BUS8: begin
        dec_bus   = 1'b1;
        dec_remap = pin_function_select_pkg::REMAP_EXT;
      end
      pin_function_select_pkg::MODE_EXT_BUS16: begin
        dec_bus   = 1'b1;
        dec_wide  = 1'b1;
        dec_remap = pin_function_select_pkg::REMAP_EXT;
      end
      pin_function_select_pkg::MODE_FLASH_BUS: begin
        dec_bus   = 1'b1;
        dec_wide  = 1'b1;
        dec_remap = pin_function_select_pkg::REMAP_FLASH;
      end
      pin_function_select_pkg::MODE_FLASH_CHIP: begin
        dec_chip  = 1'b1;
        dec_remap = pin_function_select_pkg::REMAP_FLASH;
      end
      pin_function_select_pkg::MODE_UART_BUS: begin
        dec_bus   = 1'b1;
        dec_wide  = 1'b1;
        dec_uart  = 1'b1;
        dec_remap = pin_function_select_pkg::REMAP_UART;
      end
      pin_function_select_pkg::MODE_UART_CHIP: begin
        dec_chip  = 1'b1;
        dec_uart  = 1'b1;
        dec_remap = pin_function_select_pkg::REMAP_UART;
      end
      default: begin
        dec_test  = 1'b1;
        dec_remap = pin_function_select_pkg::REMAP_TEST;
      end
    endcase
  end

  // All mode outputs move on the same capture edge, never a mixed mode
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      op_mode <= pin_function_select_pkg::OP_MODE_RST;
    end else if (capture) begin
      op_mode <= mode_dec;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_valid <= pin_function_select_pkg::MODE_VALID_RST;
    end else if (capture) begin
      mode_valid <= !dec_test;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      test_mode <= pin_function_select_pkg::TEST_MODE_RST;
    end else if (capture) begin
      test_mode <= dec_test;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mem_remap <= pin_function_select_pkg::REMAP_RST;
    end else if (capture) begin
      mem_remap <= dec_remap;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_bus_en <= pin_function_select_pkg::EXT_BUS_EN_RST;
    end else if (capture) begin
      ext_bus_en <= dec_bus;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_bus_wide <= pin_function_select_pkg::ext_bus_wide_RST;
    end else if (capture) begin
      ext_bus_wide <= dec_wide;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      single_chip_mode <= pin_function_select_pkg::CHIP_MODE_RST;
    end else if (capture) begin
      single_chip_mode <= dec_chip;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      boot_uart <= pin_function_select_pkg::BOOT_UART_RST;
    end else if (capture) begin
      boot_uart <= dec_uart;
    end
  end

  for (genvar g = 0; g < GROUPS; g++) begin : gen_grp
    logic hit;

    // Group numbers past the table are ignored
    assign hit = ovr_we && (ovr_grp == GRP_IDX_W'(g));

    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        ovr_r[g] <= '0;
      end else if (hit) begin
        ovr_r[g] <= ovr_wdata;
      end
    end

    assign mode_fn[g] = group_default(g, test_mode, ext_bus_en, ext_bus_wide,
                                      single_chip_mode, boot_uart);

    // Override wins over the mode until software clears its enable
    assign final_fn[g] = ovr_r[g].ovr_en ? ovr_r[g].fn : mode_fn[g];

    assign bus_nxt[g]   = (final_fn[g] == pin_function_select_pkg::FN_BUS);
    assign gpio_nxt[g]  = (final_fn[g] == pin_function_select_pkg::FN_GPIO);
    assign timer_nxt[g] = (final_fn[g] == pin_function_select_pkg::FN_TIMER);
    assign alt_nxt[g]   = (final_fn[g] == pin_function_select_pkg::FN_ALT);
  end

  // Registered one cycle after the mode so pads see a clean edge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_function_select <= '0;
    end else begin
      pin_function_select.bus_fn   <= bus_nxt;
      pin_function_select.gpio_fn  <= gpio_nxt;
      pin_function_select.timer_fn <= timer_nxt;
      pin_function_select.alt_fn   <= alt_nxt;
    end
  end

endmodule

/* pin_function_select_pkg.sv */
package pin_function_select_pkg;

  localparam int MODE_W = 3;

  typedef enum logic [2:0] {
    MODE_TEST0      = 3'h0,
    MODE_TEST1      = 3'h1,
    MODE_EXT_BUS8   = 3'h2,
    MODE_EXT_BUS16  = 3'h3,
    MODE_FLASH_BUS  = 3'h4,
    MODE_FLASH_CHIP = 3'h5,
    MODE_UART_BUS   = 3'h6,
    MODE_UART_CHIP  = 3'h7
  } op_mode_e;

  // Memory layout selections
  typedef enum logic [1:0] {
    REMAP_TEST  = 2'h0,
    REMAP_EXT   = 2'h1,
    REMAP_FLASH = 2'h2,
    REMAP_UART  = 2'h3
  } remap_e;

  // Per-group pin function
  typedef enum logic [1:0] {
    FN_BUS   = 2'h0,
    FN_GPIO  = 2'h1,
    FN_TIMER = 2'h2,
    FN_ALT   = 2'h3
  } pin_fn_e;

  // Software override word: one enable and one function per pin group
  typedef struct packed {
    logic    ovr_en;
    pin_fn_e fn;
  } grp_ovr_s;

  localparam int GRP_DATA_LO  = 0;
  localparam int GRP_DATA_HI  = 1;
  localparam int GRP_ADDR_LO  = 2;
  localparam int GRP_ADDR_HI  = 3;
  localparam int GRP_STROBE   = 4;
  localparam int GRP_CS_HI    = 5;
  localparam int GRP_CS_LO    = 6;
  localparam int GRP_TIMER5   = 7;
  localparam int GRP_TCLK     = 8;
  localparam int GRP_COUNT    = 9;

  // Decoded selection seen by pad logic
  typedef struct packed {
    logic [GRP_COUNT-1:0] bus_fn;
    logic [GRP_COUNT-1:0] gpio_fn;
    logic [GRP_COUNT-1:0] timer_fn;
    logic [GRP_COUNT-1:0] alt_fn;
  } pin_sel_s;

  localparam logic ext_bus_wide_RST = 1'b0;
  localparam op_mode_e OP_MODE_RST   = MODE_TEST0;
  localparam remap_e   REMAP_RST     = REMAP_TEST;
  localparam logic     MODE_VALID_RST = 1'b0;
  localparam logic     TEST_MODE_RST  = 1'b1;
  localparam logic     EXT_BUS_EN_RST = 1'b0;
  localparam logic     CHIP_MODE_RST  = 1'b0;
  localparam logic     BOOT_UART_RST  = 1'b0;
  localparam int   EXT_ADDR_BITS    = 24;
  localparam int   SYNC_STAGES      = 2;

endpackage

/* bmpm_properties.sv */
`timescale 1ns/1ns
module bmpm_properties (
  input wire logic                  clock,
  input wire logic                  reset,
  input wire pin_function_select_pkg::op_mode_e op_mode,
  input wire logic                  ext_bus_wide,
  input wire logic                  single_chip_mode,
  input wire logic                  boot_uart,
  input wire logic                  ext_bus_en,
  input wire pin_function_select_pkg::remap_e   mem_remap
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  bus_narrow_a: assert property (op_mode == 3'h2 |-> !ext_bus_wide) else $error("wide");
  chip_only_a: assert property (op_mode[0] && op_mode[2] |-> single_chip_mode) else $error("chip");
  uart_boot_a: assert property (op_mode[2:1] == 2'h3 |-> boot_uart) else $error("uart");
  wide_bus_a: assert property (op_mode == 3'h3 |-> ext_bus_wide && ext_bus_en) else $error("w16");
  flash_bus_a: assert property (op_mode == 3'h4 |-> ext_bus_en && !boot_uart) else $error("fb");
  no_bus_a: assert property (op_mode == 3'h7 |-> !ext_bus_en) else $error("nobus");
  flash_map_a: assert property (op_mode[2:1] == 2'h2 |-> mem_remap == 2'h2) else $error("map");
endmodule
bind boot_mode_pin_function_select bmpm_properties chk (.*);

/* board_straps.sv */
`timescale 1ns/1ns
module board_straps (
  input wire logic [2:0] code,
  output logic [2:0]     mode_pin
);
  assign mode_pin = code;
endmodule

/* boot_mode_pin_function_select_tb_top.sv */
`timescale 1ns/1ns
`define CHK(a,b) begin checked++; if ((a)!==(b)) begin n_errors++; $display("CHECK FAILED %0t %h %h",$time,a,b); end end
module boot_mode_pin_function_select_tb_top;
  logic clock = 0, reset = 1, rs = 0, sc, bu, w, be, ow = 0;
  logic [3:0] og = 4'h0;
  pin_function_select_pkg::grp_ovr_s owd = '0;
  pin_function_select_pkg::pin_sel_s ps;
  logic [2:0] code = 3'h2;
  wire logic [2:0] mp;
  pin_function_select_pkg::op_mode_e om;
  pin_function_select_pkg::remap_e rm;
  int n_errors = 0, checked = 0;
  board_straps b (.code(code), .mode_pin(mp));
  boot_mode_pin_function_select DUT (.clock(clock), .reset(reset), .mode_pin(mp), .resample(rs), .ovr_we(ow),
    .ovr_grp(og), .ovr_wdata(owd), .op_mode(om), .mode_valid(), .test_mode(), .mem_remap(rm),
    .ext_bus_en(be), .ext_bus_wide(w), .single_chip_mode(sc), .boot_uart(bu),
    .pin_function_select(ps));
  initial forever #5 clock = ~clock;
  task summarize;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task mode_sweep;
    for (int m = 2; m < 8; m++) begin
      @(posedge clock) #1 code = m[2:0];
      rs = 1;
      @(posedge clock) #1 rs = 0;
      for (int i = 0; i < 20 && om !== m[2:0]; i++) @(posedge clock);
      `CHK(om, m[2:0])
      `CHK(rm, (m < 4) ? 2'h1 : (m < 6) ? 2'h2 : 2'h3)
      `CHK(w, m == 3 || m == 4 || m == 6)
      `CHK(sc, m == 5 || m == 7)
      `CHK(be, m != 5 && m != 7)
    end
  endtask
  task ovr_check;
    @(posedge clock) #1 ow = 1;
    og = 4'h1;
    owd = '{ovr_en: 1'b1, fn: pin_function_select_pkg::FN_BUS};
    @(posedge clock) #1 ow = 0;
    repeat (2) @(posedge clock);
    #1;
    `CHK(ps.bus_fn[1], 1'b1)
    `CHK(ps.gpio_fn[1], 1'b0)
    `CHK(ps.timer_fn[3], 1'b1)
    `CHK(ps.gpio_fn[0], 1'b1)
    `CHK(ps.timer_fn[7], 1'b1)
    `CHK(ps.timer_fn[8], 1'b1)
    `CHK(ps.timer_fn[5], 1'b1)
  endtask
  initial begin
    repeat (10) @(posedge clock);
    #1 reset = 0;
    mode_sweep;
    ovr_check;
    summarize;
  end
endmodule
